// *** shared/ccp_link_if.sv ***
// pins between host controller and codec control port
`timescale 1ns/1ps
interface ccp_link_if;
    logic spi_sel;
    logic h_scl_o;
    logic h_scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic sclk;
    logic d_sda_o;
    logic d_sda_oe;
    logic d_miso_o;
    logic d_miso_oe;
    logic scl_ss;
    logic sda_mosi;
    logic miso;
    // pull-ups: a line is low only while an enabled driver pulls it low
    assign scl_ss = ~(h_scl_oe & ~h_scl_o);
    assign sda_mosi = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
    assign miso = d_miso_oe ? d_miso_o : 1'b1;
    modport dev (input scl_ss, input sda_mosi, input sclk, input spi_sel,
        output d_sda_o, output d_sda_oe, output d_miso_o, output d_miso_oe);
    modport host (input sda_mosi, input miso, output spi_sel, output h_scl_o,
        output h_scl_oe, output h_sda_o, output h_sda_oe, output sclk);
endinterface : ccp_link_if

// *** shared/ccp_params.svh ***
// constants of the codec control port and its host controller
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH
`define CCP_I2C_ADDR 7'h18
`define CCP_REG_PAGE 7'h00
`define CCP_PAGE_RST 8'h00
`define CCP_CLK_NS 25
`define CCP_HALF_NS 1250
`define CCP_HALF_CYC ((`CCP_HALF_NS + `CCP_CLK_NS - 1) / `CCP_CLK_NS)
`define CCP_OFF_CTRL 4'h0
`define CCP_OFF_CMD 4'h4
`define CCP_OFF_STAT 4'h8
`define CCP_OFF_RDATA 4'hc
`define CCP_CTRL_SPI 0
`define CCP_CMD_RD 8
`define CCP_CMD_WD 16
`define CCP_STAT_BUSY 0
`define CCP_STAT_NACK 1
`define CCP_RESP_OK 2'b00
`define CCP_RESP_ERR 2'b10
`endif

// *** shared/ccp_pkg.sv ***
// types shared by both ends of the codec control port
package ccp_pkg;
    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACKA, D_WR, D_ACKW, D_RD, D_ACKR, D_SPI} ccp_dev_e;
    typedef enum logic [2:0] {H_IDLE, H_BIT, H_RSTART, H_STOP, H_SPI} ccp_host_e;
endpackage : ccp_pkg

// *** testbench/ccp_link_assertions.sv ***
// concurrent checks on the pins between host controller and codec control port
`timescale 1ns/1ps
module ccp_link_assertions (
    input wire logic aclk,
    input wire logic link_clk,
    input wire logic aresetn,
    input wire logic spi_sel,
    input wire logic h_scl_o,
    input wire logic h_scl_oe,
    input wire logic h_sda_o,
    input wire logic h_sda_oe,
    input wire logic sclk,
    input wire logic scl_ss,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic d_miso_oe
);
    // strap held long enough for the device synchroniser to follow it
    sequence s_spi_held;
        spi_sel [*6];
    endsequence
    sequence s_i2c_held;
        !spi_sel [*6];
    endsequence
    // select released for a while, so the slave must have let miso go
    sequence s_desel;
        (spi_sel && scl_ss) [*6];
    endsequence
    property p_host_od;
        @(posedge aclk) disable iff (!aresetn)
            !spi_sel |-> !(h_scl_oe && h_scl_o) && !(h_sda_oe && h_sda_o);
    endproperty
    a_host_od: assert property (p_host_od) else $error("host drove i2c line high");
    property p_dev_od;
        @(posedge link_clk) disable iff (!aresetn) d_sda_oe |-> !d_sda_o;
    endproperty
    a_dev_od: assert property (p_dev_od) else $error("device drove sda high");
    property p_spi_nosda;
        @(posedge link_clk) disable iff (!aresetn) s_spi_held |-> !d_sda_oe;
    endproperty
    a_spi_nosda: assert property (p_spi_nosda) else $error("sda pulled in spi mode");
    property p_i2c_nomiso;
        @(posedge link_clk) disable iff (!aresetn) s_i2c_held |-> !d_miso_oe;
    endproperty
    a_i2c_nomiso: assert property (p_i2c_nomiso) else $error("miso on in i2c");
    // a frame must see the slave answering on miso within a few link cycles
    property p_miso_drv;
        @(posedge link_clk) disable iff (!aresetn)
            spi_sel && $fell(scl_ss) |-> ##[1:10] d_miso_oe;
    endproperty
    a_miso_drv: assert property (p_miso_drv) else $error("miso not driven in frame");
    property p_miso_off;
        @(posedge link_clk) disable iff (!aresetn) s_desel |-> !d_miso_oe;
    endproperty
    a_miso_off: assert property (p_miso_off) else $error("miso driven while idle");
    property p_sclk_idle;
        @(posedge aclk) disable iff (!aresetn) (spi_sel && scl_ss) || !spi_sel |-> !sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk high outside frame");
    property p_sclk_frame;
        @(posedge aclk) disable iff (!aresetn) $rose(sclk) |-> !scl_ss && !$past(scl_ss);
    endproperty
    a_sclk_frame: assert property (p_sclk_frame) else $error("clock before select");
endmodule : ccp_link_assertions

// *** testbench/tb_codec_control_port.sv ***
// bench: axi4-lite accesses through the host controller to the codec control port
`timescale 1ns/1ps
`include "ccp_params.svh"
module tb_codec_control_port;
    logic aclk = 1'b0;
    logic link_clk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, spi_mode, active;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata;
    logic [7:0] page;
    int n_errors = 0;
    int cmp_count = 0;
    ccp_link_if lk();
    ccp_host #(.HALF(10)) i_ccp_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .lk(lk));
    ccp_dev i_ccp_dev (.link_clk(link_clk), .aresetn(aresetn), .lk(lk), .page_o(page),
        .spi_mode_o(spi_mode), .active_o(active));
    ccp_link_assertions i_ccp_link_assertions (.aclk(aclk), .link_clk(link_clk),
        .aresetn(aresetn), .spi_sel(lk.spi_sel), .h_scl_o(lk.h_scl_o), .h_scl_oe(lk.h_scl_oe),
        .h_sda_o(lk.h_sda_o), .h_sda_oe(lk.h_sda_oe), .sclk(lk.sclk), .scl_ss(lk.scl_ss),
        .d_sda_o(lk.d_sda_o), .d_sda_oe(lk.d_sda_oe), .d_miso_oe(lk.d_miso_oe));
    // two unrelated clocks: 25 ns system, 6 ns link
    initial forever #12.5 aclk = ~aclk;
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // one write; each channel released at the edge it was taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                b = 1'b1;
                resp = bresp;
                bready <= 1'b0;
            end
        end
    endtask : axw
    task automatic axr(input logic [3:0] a, output logic [31:0] d);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                b = 1'b1;
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
            end
        end
    endtask : axr
    // launch one device access, poll busy, fetch the read byte
    task automatic dacc(input logic rd, input logic [6:0] r, input logic [7:0] d,
        output logic [7:0] q);
        logic [31:0] v;
        axw(`CCP_OFF_CMD, {8'h00, d, 7'h00, rd, 1'b0, r});
        v = 32'h1;
        while (v[`CCP_STAT_BUSY]) axr(`CCP_OFF_STAT, v);
        chk(v, 32'h0, "status after access");
        axr(`CCP_OFF_RDATA, v);
        q = v[7:0];
    endtask : dacc
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // main sequence: reset state, unmapped offsets, then both strap levels
    initial begin
        logic [7:0] q;
        logic [31:0] v;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`CCP_OFF_CTRL, v);
        chk(v, 32'h0, "ctrl reset");
        chk({24'h0, page}, 32'h0, "page reset");
        axr(4'h2, v);
        chk({30'h0, resp}, 32'h2, "unmapped read resp");
        chk(v, 32'h0, "unmapped read data");
        axw(4'h6, 32'h1);
        chk({30'h0, resp}, 32'h2, "unmapped write resp");
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            axw(`CCP_OFF_CTRL, 32'(m));
            repeat (10) @(posedge aclk);
            chk({31'h0, spi_mode}, 32'(m), "strap follow");
            dacc(1'b0, 7'h05, 8'ha5 ^ m[7:0], q);
            dacc(1'b0, 7'h00, 8'h01, q);
            chk({24'h0, page}, 32'h1, "page switched");
            dacc(1'b0, 7'h05, 8'h3c ^ m[7:0], q);
            dacc(1'b1, 7'h05, 8'h00, q);
            chk({24'h0, q}, {24'h0, 8'h3c ^ m[7:0]}, "page1 read");
            dacc(1'b1, 7'h00, 8'h00, q);
            chk({24'h0, q}, 32'h1, "page select read");
            dacc(1'b0, 7'h00, 8'h00, q);
            dacc(1'b1, 7'h05, 8'h00, q);
            chk({24'h0, q}, {24'h0, 8'ha5 ^ m[7:0]}, "page0 read");
            chk({31'h0, active}, 32'h0, "device idle");
            $display("test mode %0d done", m);
        end
        print_verdict();
    end
    // watchdog well beyond the expected run of some 9k cycles
    initial begin
        #2000000;
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule : tb_codec_control_port

// *** verilog/ccp_dev.sv ***
// codec control port: i2c target or spi slave onto a paged register file
//
// Notes on behaviour
// - strap high selects spi, low selects i2c
// - system keeps the strap fixed while running
// - i2c answers only target address 0011000
// - i2c lines are pulled low or released only
// - spi reuses scl as select, sda as mosi
// - spi clock idles low, polarity zero
// - host makes the spi clock, starts transfers
// - slave idles until select, shifts on sclk only
// - one byte out on miso per byte in
`timescale 1ns/1ps
`include "ccp_params.svh"
module ccp_dev
    import ccp_pkg::*;
#(
    parameter int PAGE_BITS = 2,
    parameter int REG_BITS = 4
) (
    input wire logic link_clk,
    input wire logic aresetn,
    ccp_link_if.dev lk,
    output logic [7:0] page_o,
    output logic spi_mode_o,
    output logic active_o
);
    localparam int NREG = 1 << (PAGE_BITS + REG_BITS);

    typedef struct packed {
        logic [1:0] scl_q;
        logic [1:0] sda_q;
        logic [1:0] sclk_q;
        logic [1:0] sel_q;
        logic scl_d;
        logic sda_d;
        logic sclk_d;
        logic spi;
        ccp_dev_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic rw;
        logic first;
        logic [6:0] ptr;
        logic [7:0] page;
        logic [NREG-1:0][7:0] mem;
        logic sda_o;
        logic sda_oe;
        logic miso;
        logic miso_oe;
        logic act;
    } ccp_dev_s;

    ccp_dev_s r;
    ccp_dev_s n;
    logic scl;
    logic sda;
    logic sclk;
    logic scl_rise;
    logic scl_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic start_c;
    logic stop_c;

    // only the second stage of each synchroniser is looked at
    assign scl = r.scl_q[1];
    assign sda = r.sda_q[1];
    assign sclk = r.sclk_q[1];
    assign scl_rise = scl & ~r.scl_d;
    assign scl_fall = ~scl & r.scl_d;
    assign sclk_rise = sclk & ~r.sclk_d;
    assign sclk_fall = ~sclk & r.sclk_d;
    assign start_c = scl & r.scl_d & r.sda_d & ~sda;
    assign stop_c = scl & r.scl_d & ~r.sda_d & sda;

    // page and register both inside the implemented array
    function automatic logic in_map(input logic [7:0] p, input logic [6:0] a);
        return ((p >> PAGE_BITS) == 8'h00) && ((a >> REG_BITS) == 7'h00);
    endfunction : in_map

    function automatic logic [7:0] reg_rd(input ccp_dev_s s, input logic [6:0] a);
        if (a == `CCP_REG_PAGE) begin
            return s.page;
        end
        if (!in_map(s.page, a)) begin
            return 8'h00;
        end
        return s.mem[{s.page[PAGE_BITS-1:0], a[REG_BITS-1:0]}];
    endfunction : reg_rd

    // writes outside the array are dropped silently
    function automatic ccp_dev_s reg_wr(input ccp_dev_s s, input logic [6:0] a,
            input logic [7:0] d);
        ccp_dev_s t;
        t = s;
        if (a == `CCP_REG_PAGE) begin
            t.page = d;
        end else if (in_map(s.page, a)) begin
            t.mem[{s.page[PAGE_BITS-1:0], a[REG_BITS-1:0]}] = d;
        end
        return t;
    endfunction : reg_wr

    // next state of the whole port
    always_comb begin
        logic load;
        logic [7:0] b;
        load = 1'b0;
        b = 8'h00;
        n = r;
        n.scl_q = {r.scl_q[0], lk.scl_ss};
        n.sda_q = {r.sda_q[0], lk.sda_mosi};
        n.sclk_q = {r.sclk_q[0], lk.sclk};
        n.sel_q = {r.sel_q[0], lk.spi_sel};
        n.scl_d = scl;
        n.sda_d = sda;
        n.sclk_d = sclk;
        n.spi = r.sel_q[1];
        n.sda_o = 1'b0;
        if (n.spi != r.spi) begin
            // strap moved: abandon whatever was running
            n.st = D_IDLE;
            n.sda_oe = 1'b0;
            n.miso_oe = 1'b0;
        end else if (r.spi) begin
            // scl pin is select, sda pin is mosi
            n.sda_oe = 1'b0;
            if (scl) begin
                n.st = D_IDLE;
                n.miso_oe = 1'b0;
            end else if (r.st != D_SPI) begin
                n.st = D_SPI;
                n.cnt = 4'h0;
                n.tx = 8'h00;
                n.first = 1'b1;
                n.miso_oe = 1'b1;
            end else if (sclk_rise) begin
                // sample on rising sclk, clock idles low
                b = {r.sh[6:0], sda};
                n.sh = b;
                n.cnt = r.cnt + 4'h1;
                if (r.cnt == 4'h7) begin
                    n.cnt = 4'h0;
                    n.tx = 8'h00;
                    if (r.first) begin
                        n.first = 1'b0;
                        n.rw = b[0];
                        n.ptr = b[7:1];
                        if (b[0]) begin
                            n.tx = reg_rd(r, b[7:1]);
                            n.ptr = b[7:1] + 7'h1;
                        end
                    end else if (r.rw) begin
                        n.tx = reg_rd(r, r.ptr);
                        n.ptr = r.ptr + 7'h1;
                    end else begin
                        n = reg_wr(n, r.ptr, b);
                        n.ptr = r.ptr + 7'h1;
                    end
                end
            end else if (sclk_fall && r.cnt != 4'h0) begin
                n.tx = {r.tx[6:0], 1'b0};
            end
        end else if (start_c) begin
            n.st = D_ADDR;
            n.cnt = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            n.st = D_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (r.st)
                D_ADDR, D_WR: begin
                    if (scl_rise && r.cnt != 4'h8) begin
                        n.sh = {r.sh[6:0], sda};
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == 4'h8) begin
                        n.sda_oe = 1'b1;
                        n.st = D_ACKW;
                        if (r.st == D_ADDR) begin
                            n.st = D_ACKA;
                            n.rw = r.sh[0];
                            n.first = 1'b1;
                            if (r.sh[7:1] != `CCP_I2C_ADDR) begin
                                n.sda_oe = 1'b0;
                                n.st = D_IDLE;
                            end
                        end else if (r.first) begin
                            n.first = 1'b0;
                            n.ptr = r.sh[6:0];
                        end else begin
                            n = reg_wr(n, r.ptr, r.sh);
                            n.ptr = r.ptr + 7'h1;
                        end
                    end
                end
                D_ACKA: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.cnt = 4'h0;
                        n.st = D_WR;
                        load = r.rw;
                    end
                end
                D_ACKW: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.cnt = 4'h0;
                        n.st = D_WR;
                    end
                end
                D_RD: begin
                    if (scl_fall && r.cnt == 4'h8) begin
                        n.sda_oe = 1'b0;
                        n.st = D_ACKR;
                    end else if (scl_fall) begin
                        n.sda_oe = ~r.tx[7];
                        n.tx = {r.tx[6:0], 1'b0};
                        n.cnt = r.cnt + 4'h1;
                    end
                end
                D_ACKR: begin
                    // a high level in the ack slot ends the read
                    if (scl_rise && sda) begin
                        n.st = D_IDLE;
                    end else if (scl_fall) begin
                        load = 1'b1;
                    end
                end
                default: begin
                    n.st = D_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end
        // put the msb of the next read byte on sda at once
        if (load) begin
            b = reg_rd(r, r.ptr);
            n.sda_oe = ~b[7];
            n.tx = {b[6:0], 1'b0};
            n.cnt = 4'h1;
            n.ptr = r.ptr + 7'h1;
            n.st = D_RD;
        end
        n.miso = n.tx[7];
        n.act = (n.st != D_IDLE);
    end

    // state register on the link clock
    always_ff @(posedge link_clk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= D_IDLE;
            r.page <= `CCP_PAGE_RST;
            r.first <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign lk.d_sda_o = r.sda_o;
    assign lk.d_sda_oe = r.sda_oe;
    assign lk.d_miso_o = r.miso;
    assign lk.d_miso_oe = r.miso_oe;
    assign page_o = r.page;
    assign spi_mode_o = r.spi;
    assign active_o = r.act;
endmodule : ccp_dev

// *** verilog/ccp_host.sv ***
// host controller: axi4-lite registers driving i2c or spi single-byte accesses
`timescale 1ns/1ps
`include "ccp_params.svh"
module ccp_host
    import ccp_pkg::*;
#(
    parameter int HALF = `CCP_HALF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    ccp_link_if.host lk
);
    typedef struct packed {
        logic awr;
        logic bv;
        logic [1:0] br;
        logic arr;
        logic rv;
        logic [1:0] rr;
        logic [31:0] rd;
        logic spi;
        logic [31:0] cmd;
        logic busy;
        logic nack;
        logic [7:0] rx;
        ccp_host_e st;
        logic [15:0] tc;
        logic [1:0] step;
        logic [4:0] bitn;
        logic [2:0] idx;
        logic [15:0] sh;
        logic [7:0] rxsh;
        logic scl_v;
        logic sda_v;
        logic sclk_v;
        logic [1:0] sda_q;
        logic [1:0] miso_q;
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } ccp_host_s;

    ccp_host_s r;
    ccp_host_s n;

    // i2c byte sequence: addr+w, register, data | addr+r, read byte
    function automatic logic [7:0] i2c_byte(input logic [2:0] i, input logic [31:0] c);
        case (i)
            3'h0: return {`CCP_I2C_ADDR, 1'b0};
            3'h1: return {1'b0, c[6:0]};
            3'h2: return c[`CCP_CMD_WD +: 8];
            3'h3: return {`CCP_I2C_ADDR, 1'b1};
            default: return 8'hff;
        endcase
    endfunction : i2c_byte

    // next state
    always_comb begin
        logic tk;
        logic sin;
        tk = (r.tc == 16'(HALF - 1));
        sin = r.sda_q[1];
        n = r;
        n.tc = (r.st == H_IDLE || tk) ? 16'h0000 : r.tc + 16'h0001;
        n.sda_q = {r.sda_q[0], lk.sda_mosi};
        n.miso_q = {r.miso_q[0], lk.miso};
        // write channel: address and data taken together
        n.awr = 1'b0;
        if (r.bv && bready) begin
            n.bv = 1'b0;
        end
        if (r.awr) begin
            n.bv = 1'b1;
            n.br = `CCP_RESP_OK;
            case (awaddr)
                `CCP_OFF_CTRL: begin
                    // strap only moves while the port is idle
                    if (!r.busy && wstrb[0]) begin
                        n.spi = wdata[`CCP_CTRL_SPI];
                    end
                end
                `CCP_OFF_CMD: begin
                    for (int i = 0; i < 4; i++) begin
                        if (wstrb[i]) begin
                            n.cmd[i*8 +: 8] = wdata[i*8 +: 8];
                        end
                    end
                    // a command written while busy is stored but not started
                    if (!r.busy && wstrb[0]) begin
                        n.busy = 1'b1;
                        n.nack = 1'b0;
                        n.bitn = 5'h00;
                        n.idx = 3'h0;
                        if (r.spi) begin
                            n.st = H_SPI;
                            n.scl_v = 1'b0;
                            n.sh = {n.cmd[6:0], n.cmd[`CCP_CMD_RD], n.cmd[`CCP_CMD_WD +: 8]};
                            n.sda_v = n.sh[15];
                        end else begin
                            n.st = H_RSTART;
                            n.step = 2'h2;
                        end
                    end
                end
                `CCP_OFF_STAT, `CCP_OFF_RDATA: begin
                    n.br = `CCP_RESP_OK;
                end
                default: n.br = `CCP_RESP_ERR;
            endcase
        end else if (!r.bv && awvalid && wvalid) begin
            n.awr = 1'b1;
        end
        // read channel
        n.arr = 1'b0;
        if (r.rv && rready) begin
            n.rv = 1'b0;
        end
        if (r.arr) begin
            n.rv = 1'b1;
            n.rr = `CCP_RESP_OK;
            n.rd = 32'h0000_0000;
            case (araddr)
                `CCP_OFF_CTRL: n.rd[`CCP_CTRL_SPI] = r.spi;
                `CCP_OFF_CMD: n.rd = r.cmd;
                `CCP_OFF_STAT: begin
                    n.rd[`CCP_STAT_BUSY] = r.busy;
                    n.rd[`CCP_STAT_NACK] = r.nack;
                end
                `CCP_OFF_RDATA: n.rd[7:0] = r.rx;
                default: n.rr = `CCP_RESP_ERR;
            endcase
        end else if (!r.rv && arvalid) begin
            n.arr = 1'b1;
        end
        // serial engine, one step per half bit period
        if (tk) begin
            case (r.st)
                H_RSTART: begin
                    n.step = r.step + 2'h1;
                    case (r.step)
                        2'h0: n.sda_v = 1'b1;
                        2'h1: n.scl_v = 1'b1;
                        2'h2: n.sda_v = 1'b0;
                        default: begin
                            n.scl_v = 1'b0;
                            n.st = H_BIT;
                            n.bitn = 5'h00;
                            n.step = 2'h0;
                            n.sh = {i2c_byte(r.idx, r.cmd), 8'h00};
                        end
                    endcase
                end
                H_BIT: begin
                    if (r.scl_v) begin
                        // sample at the end of the high phase
                        n.scl_v = 1'b0;
                        n.step = 2'h0;
                        n.bitn = r.bitn + 5'h01;
                        if (r.bitn != 5'h08) begin
                            n.rxsh = {r.rxsh[6:0], sin};
                        end else if (r.idx != 3'h4 && sin) begin
                            n.nack = 1'b1;
                            n.st = H_STOP;
                        end else if (r.idx == 3'h4) begin
                            n.rx = r.rxsh;
                            n.st = H_STOP;
                        end else if (r.idx == 3'h1 && r.cmd[`CCP_CMD_RD]) begin
                            n.st = H_RSTART;
                            n.idx = 3'h3;
                        end else if (r.idx == 3'h2) begin
                            n.st = H_STOP;
                        end else begin
                            n.idx = r.idx + 3'h1;
                            n.bitn = 5'h00;
                            n.sh = {i2c_byte(r.idx + 3'h1, r.cmd), 8'h00};
                        end
                    end else if (r.step == 2'h0) begin
                        // data moves only while scl is low
                        n.sda_v = (r.bitn != 5'h08 && r.idx != 3'h4) ? r.sh[15] : 1'b1;
                        n.sh = {r.sh[14:0], 1'b0};
                        n.step = 2'h1;
                    end else begin
                        n.scl_v = 1'b1;
                    end
                end
                H_SPI: begin
                    if (!r.sclk_v) begin
                        n.sclk_v = 1'b1;
                        // sample at the rise, before the slave can reload miso
                        n.rxsh = {r.rxsh[6:0], r.miso_q[1]};
                    end else begin
                        n.sclk_v = 1'b0;
                        n.sh = {r.sh[14:0], 1'b0};
                        n.sda_v = r.sh[14];
                        n.bitn = r.bitn + 5'h01;
                        if (r.bitn == 5'h0f) begin
                            n.rx = r.rxsh;
                            n.st = H_STOP;
                        end
                    end
                end
                H_STOP: begin
                    n.step = r.step + 2'h1;
                    if (r.spi || r.step == 2'h2) begin
                        n.scl_v = 1'b1;
                        n.sda_v = 1'b1;
                        n.busy = 1'b0;
                        n.st = H_IDLE;
                        n.step = 2'h0;
                    end else if (r.step == 2'h0) begin
                        n.sda_v = 1'b0;
                    end else begin
                        n.scl_v = 1'b1;
                    end
                end
                default: n.st = H_IDLE;
            endcase
        end
        // i2c pins only pull low; spi pins are driven both ways
        n.scl_oe = n.spi | ~n.scl_v;
        n.scl_o = n.spi & n.scl_v;
        n.sda_oe = n.spi | ~n.sda_v;
        n.sda_o = n.spi & n.sda_v;
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= H_IDLE;
            r.scl_v <= 1'b1;
            r.sda_v <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign awready = r.awr;
    assign wready = r.awr;
    assign bvalid = r.bv;
    assign bresp = r.br;
    assign arready = r.arr;
    assign rvalid = r.rv;
    assign rresp = r.rr;
    assign rdata = r.rd;
    assign lk.spi_sel = r.spi;
    assign lk.h_scl_o = r.scl_o;
    assign lk.h_scl_oe = r.scl_oe;
    assign lk.h_sda_o = r.sda_o;
    assign lk.h_sda_oe = r.sda_oe;
    assign lk.sclk = r.sclk_v;
endmodule : ccp_host
